// ==== hdl/ifp_apb_port.sv ====
// Purpose: APB slave front end of the forced-pending bank
// Assumes: Synchronous APB inputs, one clock, zero wait states
// Notes: Read data is captured in the setup cycle and held for access

`timescale 1ns/1ps
`default_nettype none

module ifp_apb_port
	import ifp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ifp_pkg::ADDR_W-1:0] paddr,
	input wire logic [ifp_pkg::IRQ_W-1:0] liveWord,
	output logic pready,
	output logic pslverr,
	output logic [ifp_pkg::DATA_W-1:0] prdata,
	output logic wrForce,
	output logic wrClear
);

	// All state of the port
	typedef struct packed {
		logic [DATA_W-1:0] rdata;
	} ifp_port_t;

	ifp_port_t st_ff;
	ifp_port_t nxt_st;
	ifp_acc_t acc;
	logic setup;
	logic access;

	// Phase and address decode
	always_comb begin
		setup = psel && !penable;
		access = psel && penable;
		if (paddr == OFS_FORCE_PEND) begin
			acc = IFP_ACC_FORCE;
		end else if (paddr == OFS_CLEAR_PEND) begin
			acc = IFP_ACC_CLEAR;
		end else begin
			acc = IFP_ACC_BAD;
		end
	end

	// Handshake: ready only while the block is clocked
	assign pready = clkEn;
	// Error answer for an unmapped address
	assign pslverr = access && clkEn && (acc == IFP_ACC_BAD);
	// Write strobes, one cycle, at the completing edge
	assign wrForce = access && clkEn && pwrite && (acc == IFP_ACC_FORCE);
	assign wrClear = access && clkEn && pwrite && (acc == IFP_ACC_CLEAR);
	// Read data from the register
	assign prdata = st_ff.rdata;

	// Next read word
	always_comb begin
		nxt_st = st_ff;
		if (setup && !pwrite) begin
			if (acc == IFP_ACC_BAD) begin
				nxt_st.rdata = RDATA_RST;
			end else begin
				nxt_st.rdata = {{(DATA_W-IRQ_W){1'b0}}, liveWord};
			end
		end
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '{rdata: RDATA_RST};
		end else if (clkEn) begin
			st_ff <= nxt_st;
		end
	end

endmodule

`default_nettype wire

// ==== hdl/ifp_force_pend.sv ====
// Purpose: Pending bank for interrupts 32-49 with force and clear words
// Assumes: Enables come from the controller; core_clk at 250 MHz
// Notes: Hardware sets win over any clear in the same cycle
//
// Behaviour
// - Bits 0-17 write one pends 32-49
// - Already pending or disabled: write ignored
// - Written zero leaves pending unchanged
// - Read returns live pending state
// - Clear-pending write one clears bit

`timescale 1ns/1ps
`default_nettype none

module ifp_force_pend
	import ifp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ifp_pkg::ADDR_W-1:0] paddr,
	input wire logic [ifp_pkg::DATA_W-1:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [ifp_pkg::DATA_W-1:0] prdata,
	input wire logic [ifp_pkg::IRQ_W-1:0] irqEnable,
	input wire logic [ifp_pkg::IRQ_W-1:0] irqEvent,
	input wire logic [ifp_pkg::IRQ_W-1:0] irqTaken,
	output logic [ifp_pkg::IRQ_W-1:0] irqPending,
	output logic irqAnyPend,
	output logic [ifp_pkg::IDX_W-1:0] irqTopIdx
);

	// All state of the bank
	typedef struct packed {
		logic [IRQ_W-1:0] pend;
		logic anyPend;
		logic [IDX_W-1:0] topIdx;
	} ifp_bank_t;

	ifp_bank_t st_ff;
	ifp_bank_t nxt_st;
	// Write strobes from the bus front end
	logic wrForce;
	logic wrClear;
	// Per-line next pending value
	logic [IRQ_W-1:0] pendNext;
	// Implemented bits of the write data
	logic [IRQ_W-1:0] wrBits;

	// Only the low field is implemented; upper write bits are dropped
	assign wrBits = pwdata[IRQ_W-1:0];

	// Bus slave front end
	ifp_apb_port u_port (
		.core_clk(core_clk),
		.rst(rst),
		.clkEn(clkEn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.liveWord(st_ff.pend),
		.pready(pready),
		.pslverr(pslverr),
		.prdata(prdata),
		.wrForce(wrForce),
		.wrClear(wrClear)
	);

	// Per-line pending update
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_W; gi = gi + 1) begin : g_line
			logic swSet;
			logic swClr;
			assign swSet = wrForce && wrBits[gi] && irqEnable[gi]
				&& !st_ff.pend[gi];
			assign swClr = (wrClear && wrBits[gi]) || irqTaken[gi];
			// Set over clear; zero bits hold
			// zero has no effect
			assign pendNext[gi] = swSet || irqEvent[gi]
				|| (st_ff.pend[gi] && !swClr);
		end
	endgenerate

	// Next state: pending word, summary and lowest pending index
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pend = pendNext;
		nxt_st.anyPend = |pendNext;
		nxt_st.topIdx = IDX_RST;
		// Lowest interrupt number wins the index
		for (int i = IRQ_W - 1; i >= 0; i--) begin
			if (pendNext[i]) begin
				nxt_st.topIdx = IDX_W'(i);
			end
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '{pend: PEND_RST, anyPend: 1'b0, topIdx: IDX_RST};
		end else if (clkEn) begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign irqPending = st_ff.pend;
	assign irqAnyPend = st_ff.anyPend;
	assign irqTopIdx = st_ff.topIdx;

endmodule

`default_nettype wire

// ==== hdl/ifp_pkg.sv ====
// Purpose: Shared constants for the forced-pending bank of interrupts 32-49
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses inside the block's own window

package ifp_pkg;

	// Number of interrupt lines kept in this bank
	localparam int unsigned NUM_IRQ = 18;
	// Interrupt number carried by bit 0
	localparam int unsigned IRQ_BASE = 32;
	// Width of the implemented pending field
	localparam int unsigned IRQ_W = NUM_IRQ;
	// Width of a pending-line index
	localparam int unsigned IDX_W = 5;

	// APB address and data widths
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// Set-pending register: write one pends, read shows live pending
	localparam logic [ADDR_W-1:0] OFS_FORCE_PEND = 12'h000;
	// Clear-pending register: write one clears, read shows live pending
	localparam logic [ADDR_W-1:0] OFS_CLEAR_PEND = 12'h004;

	// Pending state chosen after reset; software must not rely on it
	localparam logic [IRQ_W-1:0] PEND_RST = 18'h00000;
	// Read data value after reset
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
	// Index reported when no line is pending
	localparam logic [IDX_W-1:0] IDX_RST = 5'h00;

	// Cycles from access phase start to pready (zero wait states)
	localparam int unsigned APB_WAIT_CYC = 0;

	// Bus access kinds decoded from one APB transfer
	typedef enum logic [1:0] {
		IFP_ACC_NONE,
		IFP_ACC_FORCE,
		IFP_ACC_CLEAR,
		IFP_ACC_BAD
	} ifp_acc_t;

endpackage

// ==== tb/ifp_force_pend_assertions.sv ====
// Purpose: Port checks for the forced-pending bank
// Assumes: Zero wait states, irqTaken idle in checked cycles
// Notes: Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module ifp_force_pend_assertions
	import ifp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ifp_pkg::ADDR_W-1:0] paddr,
	input wire logic [ifp_pkg::DATA_W-1:0] pwdata,
	input wire logic [ifp_pkg::DATA_W-1:0] prdata,
	input wire logic [ifp_pkg::IRQ_W-1:0] irqEnable,
	input wire logic [ifp_pkg::IRQ_W-1:0] irqEvent,
	input wire logic [ifp_pkg::IRQ_W-1:0] irqTaken,
	input wire logic [ifp_pkg::IRQ_W-1:0] irqPending
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Decoded transfer phases
	logic wrF, wrC, rdS, idle;
	logic [IRQ_W-1:0] wBits, setMask;
	assign wBits = pwdata[IRQ_W-1:0];
	// A taken line may drop a bit that was already pending
	assign setMask = wBits & irqEnable & ~irqTaken;
	// No hardware set or clear in this cycle
	assign idle = (irqEvent == '0) && (irqTaken == '0);
	assign wrF = psel && penable && clkEn && pwrite && paddr == OFS_FORCE_PEND;
	assign wrC = psel && penable && clkEn && pwrite && paddr == OFS_CLEAR_PEND;
	assign rdS = psel && !penable && clkEn && !pwrite &&
		(paddr == OFS_FORCE_PEND || paddr == OFS_CLEAR_PEND);
	set_bits_a: assert property (wrF |=>
		(irqPending & $past(setMask)) == $past(setMask)) else $error("set lost");
	no_stray_a: assert property (wrF && idle |=>
		(irqPending & ~$past(irqPending) & ~$past(setMask)) == '0)
		else $error("stray pend");
	zero_write_a: assert property (wrF && wBits == '0 && idle |=>
		$stable(irqPending)) else $error("zero write changed state");
	read_live_a: assert property (rdS |=>
		prdata[IRQ_W-1:0] == $past(irqPending)) else $error("read stale");
	clear_bits_a: assert property (wrC && idle |=>
		(irqPending & $past(wBits)) == '0) else $error("clear lost");
	upper_zero_a: assert property (
		prdata[DATA_W-1:IRQ_W] == '0) else $error("upper bits set");
endmodule
bind ifp_force_pend ifp_force_pend_assertions chk (.core_clk, .rst, .clkEn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .irqEnable, .irqEvent,
	.irqTaken, .irqPending);
`default_nettype wire

// ==== tb/tb_irq_set_pending_bank2.sv ====
// Purpose: Register-level test of the forced-pending bank
// Assumes: Zero wait states; hardware lines pulsed only at the end
// Notes: Line 5 starts disabled to show gated forcing
`timescale 1ns/1ps
`default_nettype none
module tb_irq_set_pending_bank2;
	import ifp_pkg::*;
	logic core_clk = 0, rst = 1, clkEn = 1, psel = 0, penable = 0;
	logic pwrite = 0, pready;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, rd;
	logic [IRQ_W-1:0] irqEnable = 18'h3FFDF, irqEvent = '0, irqTaken = '0;
	logic [IRQ_W-1:0] irqPending;
	logic [IDX_W-1:0] irqTopIdx;
	logic pslverr, irqAnyPend, er;
	int numErrors = 0, comparisons = 0;
	ifp_force_pend dut (.core_clk, .rst, .clkEn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .pslverr, .prdata, .irqEnable, .irqEvent,
		.irqTaken, .irqPending, .irqAnyPend, .irqTopIdx);
	initial forever #2 core_clk = ~core_clk;
	// Verdict and end of run
	task automatic summarize;
		$display("Checks %0d errors %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			numErrors++;
			$display("Error %s exp %h got %h", nm, e, g);
		end
	endtask
	// One APB transfer, read data left in rd
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1) begin
			numErrors++;
			summarize();
		end
		// Read data and error answer taken at the completing edge
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Read a register and the live pending lines
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
		input logic [IDX_W-1:0] i);
		apb(0, a, '0);
		chk("prdata", e, rd);
		chk("irqPending", e, {14'h0, irqPending});
		chk("irqAnyPend", {31'h0, e != 0}, {31'h0, irqAnyPend});
		chk("irqTopIdx", {27'h0, i}, {27'h0, irqTopIdx});
		chk("pslverr", 32'h0, {31'h0, er});
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 0;
		apb(1, OFS_CLEAR_PEND, 32'hFFFFFFFF);
		rdchk(OFS_FORCE_PEND, 32'h0, 5'h00);
		apb(1, OFS_FORCE_PEND, 32'hFFFFFFFF);
		rdchk(OFS_FORCE_PEND, 32'h0003FFDF, 5'h00);
		apb(1, OFS_FORCE_PEND, 32'h0);
		rdchk(OFS_CLEAR_PEND, 32'h0003FFDF, 5'h00);
		apb(1, OFS_CLEAR_PEND, 32'h00020001);
		rdchk(OFS_FORCE_PEND, 32'h0001FFDE, 5'h01);
		irqEnable <= 18'h3FFFF;
		apb(1, OFS_FORCE_PEND, 32'hFFFFFFFF);
		rdchk(OFS_FORCE_PEND, 32'h0003FFFF, 5'h00);
		apb(0, 12'h008, '0);
		chk("unmapped", 32'h0, rd);
		chk("pslverr", 32'h1, {31'h0, er});
		// Hardware pend, frozen clock enable, then a taken line
		apb(1, OFS_CLEAR_PEND, 32'hFFFFFFFF);
		irqEvent <= 18'h00008;
		@(posedge core_clk);
		irqEvent <= '0;
		irqTaken <= 18'h00008;
		clkEn <= 0;
		repeat (2) @(posedge core_clk);
		chk("frozen", 32'h8, {14'h0, irqPending});
		chk("pready", 32'h0, {31'h0, pready});
		clkEn <= 1;
		@(posedge core_clk);
		irqTaken <= '0;
		@(posedge core_clk);
		chk("taken", 32'h0, {14'h0, irqPending});
		summarize();
	end
endmodule
`default_nettype wire
